// ---- core/swp_core.v ----
// write-protection core of a serial NOR flash: latch, status, guards, locks
//
// Contract
// - set-write-latch command sets the write latch flag.
// - latch clears on power-up, reset pair, latch-clear and every write/erase.
// - latch at zero rejects all write, program and erase commands.
// - in deep power-down only release and reset pair are honoured.
// - low lock pin with lock0 set blocks writes to guard bits and status lock bit 0.
// - guard bit4 zero: codes 1..10 protect top 64KB doubling to 32MB.
// - guard bit4 one: lowest areas; X11XX and X1011 protect whole array.
// - page write, sector and block wipe refused inside protected area.
// - full-array wipe runs only when nothing is protected.
// - guard bits written only by status write, outside hardware protection.
// - global lock sets, global unlock clears every per-block lock bit.
// - addressed lock, unlock and lock read-back act on one block.
// - per-block lock bits are volatile, cleared by reset.
// - lowest and highest blocks lock per 4KB sector.
// - scheme select picks region guard or per-block locks.
// - status byte: lock0 bit7, guard 6..2, latch bit1, busy bit0.
// - busy reads one during program, erase, status or non-volatile config write.
// - guard and lock0 writable; latch and busy are read-only.
// - lock bits 0 and 1 select software, pin, lock-down or one-time lock.
// - lock1 and lock0 zero: status writable with latch set, pin ignored.
// - lock1 zero, lock0 one: low pin locks status, high pin allows.
// - protected program or erase sets error flag; next page write or wipe start clears it.
`include "swp_consts.vh"

module swp_core (
    input wire clk,
    input wire reset,
    input wire cs_n,
    input wire sclk,
    input wire si,
    input wire wp_n,
    input wire status_lock_bit1,
    input wire protect_scheme_select,
    output reg so_o,
    output reg so_oe,
    output reg busy_flag,
    output reg write_latch_flag,
    output reg protection_error_flag,
    output reg deep_power_down
);

localparam integer OP_CYC_I = `SWP_OP_CYCLES;
// busy length cut to the counter width on purpose
localparam [15:0] OP_CYC = OP_CYC_I[15:0];
localparam [1:0] RD_NONE = 2'd0;
localparam [1:0] RD_STAT = 2'd1;
localparam [1:0] RD_FLAG = 2'd2;
localparam [1:0] RD_LOCK = 2'd3;

wire [3:0] pins_s;
wire cs_n_s = pins_s[3];
wire sclk_s = pins_s[2];
wire si_s = pins_s[1];
wire wp_n_s = pins_s[0];

reg sclk_prev_q;
reg cs_n_prev_q;
reg [2:0] bit_cnt_q;
reg [2:0] byte_cnt_q;
reg [7:0] shift_in_q;
reg [7:0] opcode_q;
reg [31:0] addr_q;
reg [7:0] data_q;
reg [1:0] rd_sel_q;
reg [2:0] out_cnt_q;
reg [7:0] out_shift_q;
reg [4:0] guard_q;
reg lock0_q;
reg [15:0] busy_cnt_q;
reg rst_armed_q;
reg [1023:0] blk_lock_q;
reg [15:0] sec_lo_q;
reg [15:0] sec_hi_q;

////////////////////////////////////////////////////////////////////////////////
// pins cross into clk before anything looks at them
swp_sync #(
    .W(4)
) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({cs_n, sclk, si, wp_n}),
    .sync_out(pins_s)
);

////////////////////////////////////////////////////////////////////////////////
// guard decode: true when block blk lies in the area chosen by g
function region_hit;
    input [4:0] g;
    input [9:0] blk;
    reg [3:0] c;
    reg [9:0] m;
    begin
        c = g[3:0];
        m = 10'h3FF << (c - 4'h1);
        if (c == 4'h0)
            region_hit = 1'b0;
        else if (c[3:2] == 2'b11 || c == 4'hB)
            region_hit = 1'b1;
        else if (g[4])
            region_hit = ((blk & m) == 10'h000);
        else
            region_hit = ((blk & m) == m);
    end
endfunction

// lock lookup; edge blocks use sector bits, whole asks for any sector
function lock_hit;
    input [9:0] blk;
    input [3:0] sec;
    input whole;
    begin
        if (blk == 10'h000)
            lock_hit = whole ? (|sec_lo_q) : sec_lo_q[sec];
        else if (blk == 10'h3FF)
            lock_hit = whole ? (|sec_hi_q) : sec_hi_q[sec];
        else
            lock_hit = blk_lock_q[blk];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// derived conditions
wire cs_act = ~cs_n_s;
wire sclk_rise = cs_act & sclk_s & ~sclk_prev_q;
wire sclk_fall = cs_act & ~sclk_s & sclk_prev_q;
wire cs_rise = cs_n_s & ~cs_n_prev_q;
wire [7:0] byte_in = {shift_in_q[6:0], si_s};
wire byte_done = sclk_rise & (bit_cnt_q == 3'd7);
wire exec = cs_rise & (bit_cnt_q == 3'd0) & (byte_cnt_q != 3'd0);
wire [9:0] tgt_blk = addr_q[25:16];
wire [3:0] tgt_sec = addr_q[15:12];
wire is_blk_op = (opcode_q == `SWP_OP_BLK_WIPE);
// hardware lock pin only counts with lock0 set; lock1 locks only while its input is high
wire sr_locked = status_lock_bit1 | (lock0_q & ~wp_n_s);
wire any_locked = (|blk_lock_q) | (|sec_lo_q) | (|sec_hi_q);
wire tgt_prot = protect_scheme_select ? region_hit(guard_q, tgt_blk)
                                      : lock_hit(tgt_blk, tgt_sec, is_blk_op);
wire any_prot = protect_scheme_select ? (guard_q[3:0] != 4'h0) : any_locked;
wire [7:0] status_byte = {lock0_q, guard_q, write_latch_flag, busy_flag};
wire [7:0] flag_byte = {~busy_flag, 5'h00, protection_error_flag, 1'b1};
wire [7:0] lock_byte = lock_hit(tgt_blk, tgt_sec, 1'b0) ? `SWP_LOCK_RD_SET : 8'h00;
reg [7:0] rd_byte;

// byte source for the output shifter, sampled fresh each byte
always @*
begin
    case (rd_sel_q)
        RD_STAT: rd_byte = status_byte;
        RD_FLAG: rd_byte = flag_byte;
        RD_LOCK: rd_byte = lock_byte;
        default: rd_byte = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// serial input: edges found on the sampled clock, bits taken on rise
always @(posedge clk or posedge reset)
begin
    if (reset)
    begin
        sclk_prev_q <= 1'b1;
        cs_n_prev_q <= 1'b1;
        bit_cnt_q <= 3'd0;
        byte_cnt_q <= 3'd0;
        shift_in_q <= 8'h00;
        opcode_q <= 8'h00;
        addr_q <= 32'h00000000;
        data_q <= 8'h00;
    end
    else
    begin
        sclk_prev_q <= sclk_s;
        cs_n_prev_q <= cs_n_s;
        if (!cs_act)
        begin
            bit_cnt_q <= 3'd0;
            if (!cs_rise)
                byte_cnt_q <= 3'd0; // count held one cycle for execution
        end
        else if (sclk_rise)
        begin
            shift_in_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'd1;
            if (bit_cnt_q == 3'd7)
            begin
                if (byte_cnt_q == 3'd0)
                    opcode_q <= byte_in;
                else if (byte_cnt_q < `SWP_NB_ADDR)
                    addr_q <= {addr_q[23:0], byte_in};
                else if (byte_cnt_q == `SWP_NB_ADDR)
                    data_q <= byte_in;
                if (byte_cnt_q != 3'd7)
                    byte_cnt_q <= byte_cnt_q + 3'd1; // saturates, longer pages ok
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// serial output: mode picked at byte end, bits launched on falling edges
always @(posedge clk or posedge reset)
begin
    if (reset)
    begin
        rd_sel_q <= RD_NONE;
        out_cnt_q <= 3'd0;
        out_shift_q <= 8'h00;
        so_o <= 1'b0;
        so_oe <= 1'b0;
    end
    else
    begin
        so_oe <= cs_act & (rd_sel_q != RD_NONE);
        if (!cs_act)
        begin
            rd_sel_q <= RD_NONE;
            out_cnt_q <= 3'd0;
        end
        else if (byte_done && byte_cnt_q == 3'd0 && !deep_power_down)
        begin
            if (byte_in == `SWP_OP_RD_STAT)
                rd_sel_q <= RD_STAT;
            else if (byte_in == `SWP_OP_RD_FLAG)
                rd_sel_q <= RD_FLAG;
        end
        else if (byte_done && byte_cnt_q == `SWP_LOCK_RD_AT && !deep_power_down
                 && !busy_flag && opcode_q == `SWP_OP_LOCK_RD)
            rd_sel_q <= RD_LOCK;
        else if (sclk_fall && rd_sel_q != RD_NONE)
        begin
            // reload each byte so a polled status tracks busy live
            out_cnt_q <= out_cnt_q + 3'd1;
            if (out_cnt_q == 3'd0)
            begin
                so_o <= rd_byte[7];
                out_shift_q <= {rd_byte[6:0], 1'b0};
            end
            else
            begin
                so_o <= out_shift_q[7];
                out_shift_q <= {out_shift_q[6:0], 1'b0};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// command execution at chip-select release
always @(posedge clk or posedge reset)
begin
    if (reset)
    begin
        write_latch_flag <= 1'b0;
        busy_flag <= 1'b0;
        busy_cnt_q <= 16'h0000;
        protection_error_flag <= 1'b0;
        deep_power_down <= 1'b0;
        rst_armed_q <= 1'b0;
        guard_q <= `SWP_GUARD_RESET;
        lock0_q <= `SWP_LOCK0_RESET;
        blk_lock_q <= {1024{1'b0}};
        sec_lo_q <= 16'h0000;
        sec_hi_q <= 16'h0000;
    end
    else
    begin
        // busy runs out on its own; no command can shorten it
        if (busy_flag)
        begin
            busy_cnt_q <= busy_cnt_q - 16'h0001;
            if (busy_cnt_q == 16'h0001)
                busy_flag <= 1'b0;
        end
        if (exec)
        begin
            rst_armed_q <= (opcode_q == `SWP_OP_RST_EN) & ~busy_flag;
            if (opcode_q == `SWP_OP_RST && rst_armed_q)
            begin
                // reset pair honoured even in deep power-down
                write_latch_flag <= 1'b0;
                deep_power_down <= 1'b0;
                protection_error_flag <= 1'b0;
                blk_lock_q <= {1024{1'b0}};
                sec_lo_q <= 16'h0000;
                sec_hi_q <= 16'h0000;
            end
            else if (deep_power_down)
            begin
                if (opcode_q == `SWP_OP_DPD_EXIT)
                    deep_power_down <= 1'b0;
            end
            else if (!busy_flag)
            begin
                case (opcode_q)
                    `SWP_OP_SET_LATCH: write_latch_flag <= 1'b1;
                    `SWP_OP_CLR_LATCH: write_latch_flag <= 1'b0;
                    `SWP_OP_STAT_WR:
                    begin
                        if (byte_cnt_q >= `SWP_NB_DATA1)
                        begin
                            write_latch_flag <= 1'b0;
                            if (write_latch_flag && !sr_locked)
                            begin
                                // only lock0 and guard bits take data
                                lock0_q <= addr_q[`SWP_ST_LOCK0];
                                guard_q <= addr_q[`SWP_ST_GUARD_HI:`SWP_ST_GUARD_LO];
                                busy_flag <= 1'b1;
                                busy_cnt_q <= OP_CYC;
                            end
                        end
                    end
                    `SWP_OP_EXT_WR, `SWP_OP_VCFG_WR:
                        write_latch_flag <= 1'b0;
                    `SWP_OP_NVCFG_WR, `SWP_OP_SEC_ERASE, `SWP_OP_SEC_PROG:
                    begin
                        write_latch_flag <= 1'b0;
                        if (write_latch_flag)
                        begin
                            busy_flag <= 1'b1;
                            busy_cnt_q <= OP_CYC;
                        end
                    end
                    `SWP_OP_PAGE_WR, `SWP_OP_SECT_WIPE, `SWP_OP_BLK_WIPE:
                    begin
                        if (byte_cnt_q >= (opcode_q == `SWP_OP_PAGE_WR ?
                                           `SWP_NB_ADDR_DATA : `SWP_NB_ADDR))
                        begin
                            write_latch_flag <= 1'b0;
                            if (write_latch_flag && tgt_prot)
                                protection_error_flag <= 1'b1;
                            else if (write_latch_flag)
                            begin
                                protection_error_flag <= 1'b0;
                                busy_flag <= 1'b1;
                                busy_cnt_q <= OP_CYC;
                            end
                        end
                    end
                    `SWP_OP_FULL_WIPE:
                    begin
                        write_latch_flag <= 1'b0;
                        if (write_latch_flag && any_prot)
                            protection_error_flag <= 1'b1;
                        else if (write_latch_flag)
                        begin
                            protection_error_flag <= 1'b0;
                            busy_flag <= 1'b1;
                            busy_cnt_q <= OP_CYC;
                        end
                    end
                    `SWP_OP_DPD: deep_power_down <= 1'b1;
                    `SWP_OP_GLB_LOCK:
                    begin
                        blk_lock_q <= {1024{1'b1}};
                        sec_lo_q <= 16'hFFFF;
                        sec_hi_q <= 16'hFFFF;
                    end
                    `SWP_OP_GLB_UNLOCK:
                    begin
                        blk_lock_q <= {1024{1'b0}};
                        sec_lo_q <= 16'h0000;
                        sec_hi_q <= 16'h0000;
                    end
                    `SWP_OP_BLK_LOCK, `SWP_OP_BLK_UNLOCK:
                    begin
                        if (byte_cnt_q >= `SWP_NB_ADDR)
                        begin
                            if (tgt_blk == 10'h000)
                                sec_lo_q[tgt_sec] <= (opcode_q == `SWP_OP_BLK_LOCK);
                            else if (tgt_blk == 10'h3FF)
                                sec_hi_q[tgt_sec] <= (opcode_q == `SWP_OP_BLK_LOCK);
                            else
                                blk_lock_q[tgt_blk] <= (opcode_q == `SWP_OP_BLK_LOCK);
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
end

endmodule

// ---- core/swp_consts.vh ----
// constants for the serial flash write-protection block
`ifndef SWP_CONSTS_VH
`define SWP_CONSTS_VH

// command opcodes
`define SWP_OP_SET_LATCH 8'h06
`define SWP_OP_CLR_LATCH 8'h04
`define SWP_OP_STAT_WR 8'h01
`define SWP_OP_EXT_WR 8'hC5
`define SWP_OP_NVCFG_WR 8'hB1
`define SWP_OP_VCFG_WR 8'h81
`define SWP_OP_PAGE_WR 8'h02
`define SWP_OP_SECT_WIPE 8'h20
`define SWP_OP_BLK_WIPE 8'hD8
`define SWP_OP_FULL_WIPE 8'hC7
`define SWP_OP_SEC_ERASE 8'h44
`define SWP_OP_SEC_PROG 8'h42
`define SWP_OP_RD_STAT 8'h05
`define SWP_OP_RD_FLAG 8'h70
`define SWP_OP_DPD 8'hB9
`define SWP_OP_DPD_EXIT 8'hAB
`define SWP_OP_RST_EN 8'h66
`define SWP_OP_RST 8'h99
`define SWP_OP_GLB_LOCK 8'h7E
`define SWP_OP_GLB_UNLOCK 8'h98
`define SWP_OP_BLK_LOCK 8'h36
`define SWP_OP_BLK_UNLOCK 8'h39
`define SWP_OP_LOCK_RD 8'h3D

// status byte field positions
`define SWP_ST_LOCK0 7
`define SWP_ST_GUARD_HI 6
`define SWP_ST_GUARD_LO 2
`define SWP_ST_LATCH 1
`define SWP_ST_BUSY 0
// flag status byte field positions
`define SWP_FL_READY 7
`define SWP_FL_PROT_ERR 1

// reset values
`define SWP_GUARD_RESET 5'h00
`define SWP_LOCK0_RESET 1'b0

// frame byte counts (opcode + 4 address bytes + data)
`define SWP_NB_DATA1 3'd2
`define SWP_NB_ADDR 3'd5
`define SWP_NB_ADDR_DATA 3'd6
`define SWP_LOCK_RD_AT 3'd4

// read-back value of a locked unit
`define SWP_LOCK_RD_SET 8'hFF

// timing
`define SWP_CLK_PERIOD_NS 10
`define SWP_OP_TIME_NS 2000
`define SWP_OP_CYCLES (`SWP_OP_TIME_NS / `SWP_CLK_PERIOD_NS)

`endif

// ---- core/swp_sync.v ----
// two-flop synchroniser for a group of asynchronous levels
module swp_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire reset,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

reg [W-1:0] meta_q;

////////////////////////////////////////////////////////////////////////////////
// first stage feeds only the second stage
always @(posedge clk or posedge reset)
begin
    if (reset)
    begin
        meta_q <= {W{1'b1}};
        sync_out <= {W{1'b1}};
    end
    else
    begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end
end

endmodule

// ---- test/swp_core_monitor.sv ----
// concurrent checks on the ports of the write-protection core
`include "swp_consts.vh"
module swp_core_monitor (
    input wire clk,
    input wire reset,
    input wire cs_n,
    input wire sclk,
    input wire si,
    input wire wp_n,
    input wire status_lock_bit1,
    input wire protect_scheme_select,
    input wire so_o,
    input wire so_oe,
    input wire busy_flag,
    input wire write_latch_flag,
    input wire protection_error_flag,
    input wire deep_power_down
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OP_CYC = `SWP_OP_CYCLES;
    reg [8:0] busy_cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // length of the busy level; a repetition of 200 would be too slow to unroll
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            busy_cnt_q <= 9'h000;
        else if (busy_flag)
            busy_cnt_q <= busy_cnt_q + 9'h001;
        else
            busy_cnt_q <= 9'h000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one clock domain, so clock and disable are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    reset_idle_a: assert property (
        $fell(reset) |-> !write_latch_flag && !busy_flag && !protection_error_flag)
        else $error("flags not clear after reset");
    busy_len_a: assert property (
        $fell(busy_flag) |-> busy_cnt_q >= OP_CYC - 1 && busy_cnt_q <= OP_CYC + 1)
        else $error("busy level has the wrong length");
    busy_latch_a: assert property (
        $rose(busy_flag) |-> ##[0:2] !write_latch_flag)
        else $error("latch still set after operation start");
    busy_err_a: assert property (
        $fell(protection_error_flag) |-> busy_flag || !write_latch_flag)
        else $error("error flag cleared with no operation start");
    err_idle_a: assert property (
        $rose(protection_error_flag) |-> (!busy_flag) [*8])
        else $error("refused operation went busy");
    latch_set_a: assert property (
        $rose(write_latch_flag) |-> !deep_power_down && !busy_flag)
        else $error("latch set while asleep or busy");
    dpd_entry_a: assert property (
        $rose(deep_power_down) |-> cs_n && !busy_flag)
        else $error("power-down entered at a wrong moment");
    oe_frame_a: assert property (
        $rose(so_oe) |-> !cs_n)
        else $error("output enabled outside a frame");
    oe_release_a: assert property (
        cs_n [*6] |-> !so_oe)
        else $error("output still enabled after deselect");
endmodule

// ---- test/swp_host_model.sv ----
// host serial controller model that sends command frames to the core
module swp_host_model (
    input wire clk,
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire so_o,
    input wire so_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: deselected, serial clock parked low
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one frame, MSB first, 160 ns serial clock that runs only inside the frame
    task automatic xfer(input int nb, input logic [47:0] data, output logic [7:0] rd);
        int k;
        rd = 8'h00;
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (k = 0; k < nb * 8; k++)
        begin
            si <= data[47 - k];
            repeat (8) @(posedge clk);
            sclk <= 1'b1;
            rd = {rd[6:0], (so_oe === 1'b1) ? so_o : 1'bx}; // undriven line reads unknown
            repeat (8) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si; // released line must not keep its last value
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- test/swp_core_test.sv ----
// self-checking bench for the write-protection core
`include "swp_consts.vh"
module swp_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wp_n = 1'b1;
    logic status_lock_bit1 = 1'b0;
    logic protect_scheme_select = 1'b1;
    wire cs_n, sclk, si, so_o, so_oe;
    wire busy_flag, write_latch_flag, protection_error_flag, deep_power_down;
    int n_errors = 0;
    int tests_run = 0;
    logic [7:0] rd;

    always #5 clk = ~clk;

    swp_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o),
        .so_oe(so_oe));
    swp_core dut (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n),
        .status_lock_bit1(status_lock_bit1), .protect_scheme_select(protect_scheme_select),
        .so_o(so_o), .so_oe(so_oe), .busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
        .protection_error_flag(protection_error_flag), .deep_power_down(deep_power_down));

    ////////////////////////////////////////////////////////////////////////////
    // verdict, compare and frame helpers
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // flags packed as power-down, latch, busy, error
    function automatic logic [7:0] flg();
        return {4'h0, deep_power_down, write_latch_flag, busy_flag, protection_error_flag};
    endfunction
    task automatic op(input logic [7:0] code);
        host.xfer(1, {code, 40'h0}, rd);
    endtask
    task automatic op_a(input logic [7:0] code, input logic [31:0] addr);
        host.xfer(6, {code, addr, 8'h00}, rd);
    endtask
    task automatic rd_stat;
        host.xfer(2, {`SWP_OP_RD_STAT, 40'h0}, rd);
    endtask
    // bounded wait; a busy level that never ends is counted here
    task automatic wait_idle;
        int i;
        for (i = 0; i < 300 && busy_flag === 1'b1; i++)
            @(posedge clk);
        chk("busy", 8'h00, {7'h00, busy_flag});
    endtask
    task automatic wr_stat(input logic [7:0] v);
        op(`SWP_OP_SET_LATCH);
        host.xfer(2, {`SWP_OP_STAT_WR, v, 32'h0}, rd);
        wait_idle;
    endtask
    task automatic try_wipe(input logic [7:0] code, input logic [31:0] addr, input logic hit);
        op(`SWP_OP_SET_LATCH);
        op_a(code, addr);
        chk("wipe outcome", hit ? 8'h01 : 8'h02, flg());
        wait_idle;
    endtask
    task automatic do_reset;
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_latch;
        rd_stat;
        chk("status", 8'h00, rd);
        op(`SWP_OP_SET_LATCH);
        chk("flags", 8'h04, flg());
        rd_stat;
        chk("status", 8'h02, rd);
        op(`SWP_OP_CLR_LATCH);
        chk("flags", 8'h00, flg());
        op_a(`SWP_OP_PAGE_WR, 32'h0000_1000);
        chk("flags", 8'h00, flg());
        op(`SWP_OP_SET_LATCH);
        op(`SWP_OP_RST_EN);
        op(`SWP_OP_RST);
        chk("flags", 8'h00, flg());
    endtask
    task automatic t_clear;
        logic [7:0] codes [10];
        int i;
        codes = '{`SWP_OP_STAT_WR, `SWP_OP_EXT_WR, `SWP_OP_NVCFG_WR, `SWP_OP_VCFG_WR,
            `SWP_OP_PAGE_WR, `SWP_OP_SECT_WIPE, `SWP_OP_BLK_WIPE, `SWP_OP_FULL_WIPE,
            `SWP_OP_SEC_ERASE, `SWP_OP_SEC_PROG};
        for (i = 0; i < 10; i++)
        begin
            op(`SWP_OP_SET_LATCH);
            op_a(codes[i], 32'h0010_0000);
            chk("latch", 8'h00, flg() & 8'h04);
            wait_idle;
        end
    endtask
    task automatic t_status;
        wp_n <= 1'b0;
        op(`SWP_OP_SET_LATCH);
        host.xfer(2, {`SWP_OP_STAT_WR, 8'h87, 32'h0}, rd);
        chk("flags", 8'h02, flg());
        wait_idle;
        rd_stat;
        chk("status", 8'h84, rd);
        wr_stat(8'h00);
        rd_stat;
        chk("status", 8'h84, rd);
        wp_n <= 1'b1;
        wr_stat(8'h80);
        rd_stat;
        chk("status", 8'h80, rd);
        status_lock_bit1 <= 1'b1;
        wr_stat(8'h00);
        rd_stat;
        chk("status", 8'h80, rd);
        status_lock_bit1 <= 1'b0;
        wr_stat(8'h00);
        rd_stat;
        chk("status", 8'h00, rd);
    endtask
    // inside and outside edge of each area; the last two codes cover the array
    task automatic t_guard;
        logic [4:0] g [6];
        logic [31:0] ins [6];
        logic [31:0] outs [4];
        int i;
        g = '{5'h01, 5'h0A, 5'h11, 5'h1A, 5'h0C, 5'h0B};
        ins = '{32'h03FF_0000, 32'h0200_0000, 32'h0000_F000, 32'h01FF_0000, 32'h0100_0000,
            32'h0000_0000};
        outs = '{32'h03FE_F000, 32'h01FF_F000, 32'h0001_0000, 32'h0200_0000};
        for (i = 0; i < 6; i++)
        begin
            wr_stat({1'b0, g[i], 2'b00});
            try_wipe(`SWP_OP_SECT_WIPE, ins[i], 1'b1);
            if (i < 4)
                try_wipe(`SWP_OP_BLK_WIPE, outs[i], 1'b0);
        end
        op(`SWP_OP_SET_LATCH);
        op(`SWP_OP_FULL_WIPE);
        chk("flags", 8'h01, flg());
        host.xfer(2, {`SWP_OP_RD_FLAG, 40'h0}, rd);
        chk("flag status", 8'h83, rd);
        wr_stat(8'h00);
        try_wipe(`SWP_OP_FULL_WIPE, 32'h0, 1'b0);
    endtask
    task automatic lock_is(input logic [31:0] addr, input logic [7:0] exp);
        op_a(`SWP_OP_LOCK_RD, addr);
        chk("lock read", exp, rd);
    endtask
    task automatic t_blocks;
        protect_scheme_select <= 1'b0;
        op_a(`SWP_OP_BLK_LOCK, 32'h0005_0000);
        lock_is(32'h0005_8000, 8'hFF);
        lock_is(32'h0006_0000, 8'h00);
        try_wipe(`SWP_OP_SECT_WIPE, 32'h0005_8000, 1'b1);
        op_a(`SWP_OP_BLK_UNLOCK, 32'h0005_0000);
        try_wipe(`SWP_OP_SECT_WIPE, 32'h0005_8000, 1'b0);
        op_a(`SWP_OP_BLK_LOCK, 32'h03FF_3000);
        lock_is(32'h03FF_3000, 8'hFF);
        lock_is(32'h03FF_4000, 8'h00);
        try_wipe(`SWP_OP_BLK_WIPE, 32'h03FF_8000, 1'b1);
        op(`SWP_OP_GLB_UNLOCK);
        lock_is(32'h03FF_3000, 8'h00);
        op(`SWP_OP_GLB_LOCK);
        lock_is(32'h0123_0000, 8'hFF);
        protect_scheme_select <= 1'b1;
        try_wipe(`SWP_OP_SECT_WIPE, 32'h0123_0000, 1'b0);
        do_reset;
        lock_is(32'h0123_0000, 8'h00);
    endtask
    task automatic t_dpd;
        op(`SWP_OP_DPD);
        op(`SWP_OP_SET_LATCH);
        chk("flags", 8'h08, flg());
        op(`SWP_OP_DPD_EXIT);
        chk("flags", 8'h00, flg());
        op(`SWP_OP_SET_LATCH);
        op(`SWP_OP_DPD);
        op(`SWP_OP_RST_EN);
        op(`SWP_OP_RST);
        chk("latch", 8'h00, flg() & 8'h04);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence, then a watchdog well above the expected 47k cycles
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_latch;
        t_clear;
        t_status;
        t_guard;
        t_blocks;
        t_dpd;
        end_sim;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_sim;
    end
endmodule

bind swp_core swp_core_monitor mon (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
    .si(si), .wp_n(wp_n), .status_lock_bit1(status_lock_bit1),
    .protect_scheme_select(protect_scheme_select), .so_o(so_o), .so_oe(so_oe),
    .busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
    .protection_error_flag(protection_error_flag), .deep_power_down(deep_power_down));
